/* hw/spdc_dev_ctrl_stat.v */
// Port device control and device status register pair of a switch port
`timescale 1ns/100ps
`default_nettype none
`include "spdc_map.vh"


module spdc_dev_ctrl_stat (
	input  wire        MCLK_IN,
	input  wire        RESET_N_IN,
	// Configuration access, one dword at the pair's offset
	input  wire [7:0]  CFG_ADDR_IN,
	input  wire        CFG_WR_IN,
	input  wire        CFG_RD_IN,
	input  wire [3:0]  CFG_BE_IN,
	input  wire [31:0] CFG_WDATA_IN,
	output reg  [31:0] CFG_RDATA_OUT,
	// Preload path from serial EEPROM or two-wire management bus
	input  wire        PRELOAD_WR_IN,
	input  wire [31:0] PRELOAD_DATA_IN,
	// Error events, one-cycle pulses, and the live aux power detect level
	input  wire        ERR_COR_IN,
	input  wire        ERR_NONFATAL_IN,
	input  wire        ERR_FATAL_IN,
	input  wire        ERR_UNSUP_IN,
	input  wire        AUX_PWR_DET_IN,
	// Error message requests upstream, one-cycle pulses, and the max payload size code
	output reg         MSG_COR_OUT,
	output reg         MSG_NONFATAL_OUT,
	output reg         MSG_FATAL_OUT,
	output reg         MSG_UNSUP_OUT,
	output reg  [2:0]  MAX_PAYLOAD_OUT
);

	// ----------------------------------------------------------------
	// Decode and state
	// ----------------------------------------------------------------
	reg  [3:0] err_en_r;
	reg  [3:0] err_en_nxt;
	reg  [2:0] mps_r;
	reg  [2:0] mps_nxt;
	wire [3:0] err_stat;
	wire [3:0] err_evt;
	wire [3:0] w1c;
	wire [3:0] pl_load;
	wire       hit;
	wire       cfg_wr;
	wire       rd_hit;
	wire       ctl_lane;
	wire       sta_lane;
	reg  [3:0] msg_nxt;
	reg [31:0] rd_word;

	// Larger codes are reserved or unsupported, so clamp rather than refuse
	function [2:0] spdc_clamp_mps;
		input [2:0] code;
		begin
			if (code > `SPDC_MPS_SUPPORTED) begin
				spdc_clamp_mps = `SPDC_MPS_SUPPORTED;
			end else begin
				spdc_clamp_mps = code;
			end
		end
	endfunction

	// Byte-lane gate shared by the control and status halves
	function spdc_lane;
		input       wr;
		input [3:0] be;
		input [1:0] lane;
		begin
			spdc_lane = wr & be[lane];
		end
	endfunction

	// ----------------------------------------------------------------
	// Address and byte-lane decode
	// ----------------------------------------------------------------
	assign hit      = (CFG_ADDR_IN == `SPDC_OFS_DEV_CTRL_STAT);
	assign cfg_wr   = CFG_WR_IN & hit;
	assign rd_hit   = CFG_RD_IN & hit;
	assign ctl_lane = spdc_lane(cfg_wr, CFG_BE_IN, 2'h0);
	// A preload rewrites status except for bits set by a same-cycle error event, so a same-cycle clear must not touch it
	assign sta_lane = spdc_lane(cfg_wr, CFG_BE_IN, 2'h2) & ~PRELOAD_WR_IN;
	// Event order matches the enable and status bit order
	assign err_evt  = {ERR_UNSUP_IN, ERR_FATAL_IN, ERR_NONFATAL_IN, ERR_COR_IN};
	assign w1c      = sta_lane ?
		CFG_WDATA_IN[`SPDC_STA_ERR_HI:`SPDC_STA_ERR_LO] : 4'h0;
	assign pl_load  = PRELOAD_WR_IN ? 4'hf : 4'h0;

	// ----------------------------------------------------------------
	// Control half
	// ----------------------------------------------------------------
	// Preload wins over a same-cycle configuration write; it only runs at boot
	always @* begin
		err_en_nxt = err_en_r;
		if (PRELOAD_WR_IN) begin
			err_en_nxt = PRELOAD_DATA_IN[`SPDC_CTL_UR_EN:`SPDC_CTL_COR_EN];
		end else if (ctl_lane) begin
			err_en_nxt = CFG_WDATA_IN[`SPDC_CTL_UR_EN:`SPDC_CTL_COR_EN];
		end
	end

	// Both write sources pass the clamp, so no path can store an unsupported code
	always @* begin
		mps_nxt = mps_r;
		if (PRELOAD_WR_IN) begin
			mps_nxt = spdc_clamp_mps(PRELOAD_DATA_IN[`SPDC_CTL_MPS_HI:`SPDC_CTL_MPS_LO]);
		end else if (ctl_lane) begin
			mps_nxt = spdc_clamp_mps(CFG_WDATA_IN[`SPDC_CTL_MPS_HI:`SPDC_CTL_MPS_LO]);
		end
	end

	// Reporting starts disabled and the payload at the smallest size
	always @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			err_en_r <= `SPDC_RST_ERR_EN;
		end else begin
			err_en_r <= err_en_nxt;
		end
	end

	always @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			mps_r <= `SPDC_RST_MPS;
		end else begin
			mps_r <= mps_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Status half
	// ----------------------------------------------------------------
	spdc_sticky_bits u_sticky (
		.clk_in      (MCLK_IN),
		.reset_n_in  (RESET_N_IN),
		.set_in      (err_evt),
		.clr_in      (w1c),
		.load_en_in  (pl_load),
		.load_val_in (PRELOAD_DATA_IN[`SPDC_STA_ERR_HI:`SPDC_STA_ERR_LO]),
		.flags_out   (err_stat)
	);

	// ----------------------------------------------------------------
	// Read word assembly
	// ----------------------------------------------------------------
	// Each field is placed by name, so a hardwired bit cannot pick up stored state
	always @* begin
		// Bits 15 and 31:22 are reserved and keep this default zero
		rd_word = 32'h0000_0000;
		rd_word[`SPDC_CTL_UR_EN:`SPDC_CTL_COR_EN] = err_en_r;
		rd_word[`SPDC_CTL_RELAX] = 1'b0;
		rd_word[`SPDC_CTL_MPS_HI:`SPDC_CTL_MPS_LO] = mps_r;
		rd_word[`SPDC_CTL_XTAG] = 1'b0;
		rd_word[`SPDC_CTL_PHANTOM] = 1'b0;
		rd_word[`SPDC_CTL_AUXPM] = 1'b0;
		rd_word[`SPDC_CTL_NOSNOOP] = 1'b0;
		rd_word[`SPDC_CTL_MRRS_HI:`SPDC_CTL_MRRS_LO] = 3'h0;
		rd_word[`SPDC_STA_ERR_HI:`SPDC_STA_ERR_LO] = err_stat;
		rd_word[`SPDC_STA_AUXPWR] = AUX_PWR_DET_IN;
		rd_word[`SPDC_STA_TPEND] = 1'b0;
	end

	// Reporting is gated by the enables; logging in status is not
	always @* begin
		msg_nxt = err_evt & err_en_r;
	end

	// ----------------------------------------------------------------
	// Read data register
	// ----------------------------------------------------------------
	// Read data returns to zero outside a read so a stale word is never seen
	always @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			CFG_RDATA_OUT <= 32'h0000_0000;
		end else if (rd_hit) begin
			CFG_RDATA_OUT <= rd_word;
		end else begin
			CFG_RDATA_OUT <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Message requests and payload output
	// ----------------------------------------------------------------
	always @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			MSG_COR_OUT      <= 1'b0;
			MSG_NONFATAL_OUT <= 1'b0;
			MSG_FATAL_OUT    <= 1'b0;
			MSG_UNSUP_OUT    <= 1'b0;
		end else begin
			MSG_COR_OUT      <= msg_nxt[0];
			MSG_NONFATAL_OUT <= msg_nxt[1];
			MSG_FATAL_OUT    <= msg_nxt[2];
			MSG_UNSUP_OUT    <= msg_nxt[3];
		end
	end

	// A one-cycle lag behind the field is harmless: the size only changes at setup
	always @(posedge MCLK_IN) begin
		if (!RESET_N_IN) begin
			MAX_PAYLOAD_OUT <= `SPDC_RST_MPS;
		end else begin
			MAX_PAYLOAD_OUT <= mps_r;
		end
	end

endmodule // spdc_dev_ctrl_stat

`default_nettype wire

/* hw/spdc_map.vh */
// Offsets, field positions, reset values and codes of the port device control/status pair
`ifndef SPDC_MAP_VH
`define SPDC_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPDC_OFS_DEV_CTRL_STAT  8'h70

// ----------------------------------------------------------------
// Control half, bits 15:0
// ----------------------------------------------------------------
`define SPDC_CTL_COR_EN         0
`define SPDC_CTL_NF_EN          1
`define SPDC_CTL_FAT_EN         2
`define SPDC_CTL_UR_EN          3
`define SPDC_CTL_RELAX          4
`define SPDC_CTL_MPS_LO         5
`define SPDC_CTL_MPS_HI         7
`define SPDC_CTL_XTAG           8
`define SPDC_CTL_PHANTOM        9
`define SPDC_CTL_AUXPM          10
`define SPDC_CTL_NOSNOOP        11
`define SPDC_CTL_MRRS_LO        12
`define SPDC_CTL_MRRS_HI        14

// ----------------------------------------------------------------
// Status half, bits 31:16
// ----------------------------------------------------------------
`define SPDC_STA_ERR_LO         16
`define SPDC_STA_ERR_HI         19
`define SPDC_STA_AUXPWR         20
`define SPDC_STA_TPEND          21

// ----------------------------------------------------------------
// Reset values and payload codes
// ----------------------------------------------------------------
`define SPDC_RST_ERR_EN         4'h0
`define SPDC_RST_MPS            3'h0
`define SPDC_RST_ERR_STAT       4'h0
`define SPDC_MPS_SUPPORTED      3'h1

`endif

/* hw/spdc_sticky_bits.v */
// Four sticky error flags: set by hardware, cleared by writing one
`timescale 1ns/100ps
`default_nettype none
`include "spdc_map.vh"

module spdc_sticky_bits (
	input  wire       clk_in,
	input  wire       reset_n_in,
	input  wire [3:0] set_in,
	input  wire [3:0] clr_in,
	input  wire [3:0] load_en_in,
	input  wire [3:0] load_val_in,
	output reg  [3:0] flags_out
);

	reg [3:0] flags_nxt;

	// Set wins over a clear in the same cycle so no event is lost
	always @* begin
		flags_nxt = flags_out;
		flags_nxt = (flags_nxt & ~load_en_in) | (load_val_in & load_en_in);
		flags_nxt = flags_nxt & ~clr_in;
		flags_nxt = flags_nxt | set_in;
	end

	always @(posedge clk_in) begin
		if (!reset_n_in) begin
			flags_out <= `SPDC_RST_ERR_STAT;
		end else begin
			flags_out <= flags_nxt;
		end
	end

endmodule // spdc_sticky_bits

`default_nettype wire

/* bench/spdc_asserts.sv */
// Port-level assertions for the device control/status pair
`timescale 1ns/100ps
`default_nettype none
module spdc_asserts (
	input wire        MCLK_IN,
	input wire        RESET_N_IN,
	input wire [7:0]  CFG_ADDR_IN,
	input wire        CFG_RD_IN,
	input wire [31:0] CFG_RDATA_OUT,
	input wire        ERR_COR_IN,
	input wire        ERR_FATAL_IN,
	input wire        AUX_PWR_DET_IN,
	input wire        MSG_COR_OUT,
	input wire [2:0]  MAX_PAYLOAD_OUT
);
	wire cfg_read = CFG_RD_IN && CFG_ADDR_IN == 8'h70;
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	tpend_zero_a: assert property (!CFG_RDATA_OUT[21]) else $error("pending bit set");
	req_zero_a: assert property (CFG_RDATA_OUT[14:8] == 7'h0) else $error("ctrl 14:8 set");
	relax_zero_a: assert property (!CFG_RDATA_OUT[4]) else $error("relax bit set");
	mps_clamp_a: assert property (CFG_RDATA_OUT[7:5] <= 3'h1 && MAX_PAYLOAD_OUT <= 3'h1)
		else $error("payload over limit");
	aux_live_a: assert property ($past(cfg_read) |-> CFG_RDATA_OUT[20] == $past(AUX_PWR_DET_IN))
		else $error("aux bit wrong");
	cor_log_a: assert property (ERR_COR_IN ##1 cfg_read |=> CFG_RDATA_OUT[16])
		else $error("cor flag lost");
	fat_log_a: assert property (ERR_FATAL_IN ##1 cfg_read |=> CFG_RDATA_OUT[18])
		else $error("fatal flag lost");
	msg_cause_a: assert property (MSG_COR_OUT |-> $past(ERR_COR_IN)) else $error("stray msg");
endmodule // spdc_asserts
bind spdc_dev_ctrl_stat spdc_asserts spdc_asserts_i (.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN),
	.CFG_ADDR_IN(CFG_ADDR_IN), .CFG_RD_IN(CFG_RD_IN), .CFG_RDATA_OUT(CFG_RDATA_OUT),
	.ERR_COR_IN(ERR_COR_IN), .ERR_FATAL_IN(ERR_FATAL_IN), .AUX_PWR_DET_IN(AUX_PWR_DET_IN),
	.MSG_COR_OUT(MSG_COR_OUT), .MAX_PAYLOAD_OUT(MAX_PAYLOAD_OUT));
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the device control/status pair
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  be = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        pre = 1'b0;
	logic [31:0] pdata = 32'h0;
	logic [3:0]  errs = 4'h0;
	logic        aux = 1'b0;
	wire  [31:0] rdata;
	wire  [3:0]  msg;
	wire  [2:0]  mps_o;
	logic [3:0]  en = 4'h0;
	logic [3:0]  stat = 4'h0;
	logic [2:0]  mps = 3'h0;
	logic [31:0] d;
	int          mismatches = 0;
	int          check_count = 0;
	always #12.5 clk = ~clk;
	spdc_dev_ctrl_stat spdc_dev_ctrl_stat_i (.MCLK_IN(clk), .RESET_N_IN(rst_n),
		.CFG_ADDR_IN(addr), .CFG_WR_IN(wr), .CFG_RD_IN(rd), .CFG_BE_IN(be),
		.CFG_WDATA_IN(wdata), .CFG_RDATA_OUT(rdata), .PRELOAD_WR_IN(pre),
		.PRELOAD_DATA_IN(pdata), .ERR_COR_IN(errs[0]), .ERR_NONFATAL_IN(errs[1]),
		.ERR_FATAL_IN(errs[2]), .ERR_UNSUP_IN(errs[3]), .AUX_PWR_DET_IN(aux),
		.MSG_COR_OUT(msg[0]), .MSG_NONFATAL_OUT(msg[1]), .MSG_FATAL_OUT(msg[2]),
		.MSG_UNSUP_OUT(msg[3]), .MAX_PAYLOAD_OUT(mps_o));
	function automatic [2:0] clamp(input [2:0] c);
		clamp = (c > 3'h1) ? 3'h1 : c;
	endfunction
	task automatic chk(input [31:0] g, input [31:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Preload and config write share one driver; preload wins, so never both
	task automatic put(input logic p, input [7:0] a, input [3:0] b, input [31:0] v);
		@(posedge clk) #1;
		{pre, wr, addr, be, wdata, pdata} = {p, !p, a, b, v, v};
		@(posedge clk) #1;
		{pre, wr} = 2'b00;
		if (p || (a == 8'h70 && b[0])) begin
			en = v[3:0];
			mps = clamp(v[7:5]);
		end
		if (p)
			stat = v[19:16];
		else if (a == 8'h70 && b[2])
			stat = stat & ~v[19:16];
	endtask
	// Error pulse, then a read strobed right behind it
	task automatic get(input [7:0] a, input [3:0] e);
		@(posedge clk) #1;
		errs = e;
		@(posedge clk) #1;
		errs = 4'h0;
		chk({28'h0, msg}, {28'h0, e & en});
		stat = stat | e;
		{rd, addr} = {1'b1, a};
		@(posedge clk) #1;
		rd = 1'b0;
		chk(rdata, (a == 8'h70) ? {11'h0, aux, stat, 8'h0, mps, 1'b0, en} : 32'h0);
		chk({29'h0, mps_o}, {29'h0, mps});
	endtask
	initial begin
		void'($urandom(83));
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		get(8'h70, 4'h0);
		for (int i = 0; i < 40; i++) begin
			d = (i == 0) ? 32'hffff_ffff : $urandom;
			aux = d[20];
			put(i % 9 == 8, (i % 5 == 4) ? d[31:24] : 8'h70, d[27:24], d);
			get((i % 7 == 6) ? 8'h74 : 8'h70, d[15:12]);
		end
		// Error pulse in the very cycle of a clearing write: the set must survive
		@(posedge clk) #1;
		{wr, addr, be, wdata, errs} = {1'b1, 8'h70, 4'h4, 32'h000f_0000, 4'h5};
		@(posedge clk) #1;
		{wr, errs} = 5'h00;
		chk({28'h0, msg}, {28'h0, 4'h5 & en});
		stat = 4'h5;
		get(8'h70, 4'h0);
		// Second reset in mid-run: every field but the live aux power bit returns to its reset value
		@(posedge clk) #1;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		{en, stat, mps} = 11'h000;
		get(8'h70, 4'h0);
		wrap_up();
	end
	initial begin
		#(25 * 5000);
		mismatches++;
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
